//--- design/cam_top.sv
// counter array compare/capture module with an AXI4-Lite register slave
//
// Overview of operation
// - capture edge: rising, falling or both, only with compare and pwm bits clear
// - on a valid capture edge copy counter into compare registers
// - interrupt requested while module_flag, module_irq_en and the flag's mask bit are all set
// - software timer: set module_flag when counter equals compare value
// - high-speed output: toggle module_pin each time counter equals compare value
// - buffered 8-bit pwm: low while counter_lo below compare_lo, else high
// - buffered 8-bit pwm: copy compare_hi into compare_lo at counter_lo rollover
// - buffered 8-bit pwm selected by compare_enable and pwm_enable only
// - 16-bit pwm: low while counter below compare value, direct comparison
// - 16-bit pwm selected by compare_enable, match_flag_en and pwm_enable
// - double channel: primary from compare_lo, secondary from compare_hi
// - double channel selected by compare_enable, match_toggle_en and pwm_enable
// - module_flag set by hardware on match or capture, cleared only by software
// - pwm_invert inverts the pwm waveform on module_pin
// - counter counts only while counter_run is set
`timescale 1ns/1ps
module cam_top
    import cam_pkg::*;
#(
    parameter int ADDR_W = 8
)(
    // clock, reset, enable
    input  wire logic        aclk,
    input  wire logic        aresetn,
    input  wire logic        clk_en,
    // axi4-lite write address
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // module pin
    input  wire logic        module_pin_i,
    output logic             module_pin_o,
    output logic             module_pin_oe,
    output logic             secondary_pwm_out,
    // interrupt
    output logic             irq
);
    // the register map needs five address bits; wider than a word address makes no sense
    if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_w_check
        $error("cam_top: ADDR_W out of range");
    end

    // ****************************************
    // registers
    // ****************************************
    logic [7:0]  mode_r;
    logic        run_r;
    logic [15:0] cnt_r, cnt_nxt;
    logic [15:0] reload_r;
    logic [15:0] cmp_r, cmp_nxt;
    logic [CAM_STAT_W-1:0] stat_r, stat_nxt, mask_r;
    logic        pin_q_r;
    logic        hs_r;
    logic        pwm_r;
    logic        sec_r;
    cam_mode_e   mode;

    cam_mode_dec u_dec (
        .mode_bits (mode_r),
        .mode      (mode)
    );

    function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
        merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
    endfunction

    // ****************************************
    // axi4-lite slave
    // ****************************************
    // one outstanding write and one read; address and data latched separately
    logic              aw_hold_r, w_hold_r;
    logic [ADDR_W-1:0] aw_addr_r;
    logic [31:0]       w_data_r;
    logic [3:0]        w_strb_r;
    logic              bvalid_r, rvalid_r;
    logic [1:0]        bresp_r, rresp_r;
    logic [31:0]       rdata_r;

    assign s_axi_awready = !aw_hold_r && !bvalid_r;
    assign s_axi_wready  = !w_hold_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;

    wire logic        wr_fire = aw_hold_r && w_hold_r && clk_en;
    wire logic        rd_fire = s_axi_arvalid && s_axi_arready && clk_en;
    wire logic [7:0]  wa      = 8'(aw_addr_r);
    wire logic [7:0]  ra      = 8'(s_axi_araddr);
    wire logic        wr_ctrl = wr_fire && wa == CAM_OFF_CTRL;
    wire logic        wr_mode = wr_fire && wa == CAM_OFF_MODE;
    wire logic        wr_cnt  = wr_fire && wa == CAM_OFF_CNT;
    wire logic        wr_rld  = wr_fire && wa == CAM_OFF_RELOAD;
    wire logic        wr_cmp  = wr_fire && wa == CAM_OFF_CMP;
    wire logic        wr_stat = wr_fire && wa == CAM_OFF_STAT;
    wire logic        wr_mask = wr_fire && wa == CAM_OFF_MASK;
    wire logic        wr_ok   = wr_ctrl || wr_mode || wr_cnt || wr_rld || wr_cmp || wr_stat || wr_mask
                                || (wr_fire && wa == CAM_OFF_PIN);
    wire logic        rd_stat = rd_fire && ra == CAM_OFF_STAT;

    logic [31:0] rd_mux;
    logic        rd_ok;
    always_comb begin
        rd_ok  = 1'b1;
        rd_mux = 32'h0000_0000;
        unique case (ra)
            CAM_OFF_CTRL:   rd_mux = {31'h0000_0000, run_r};
            CAM_OFF_MODE:   rd_mux = {24'h00_0000, mode_r};
            CAM_OFF_CNT:    rd_mux = {16'h0000, cnt_r};
            CAM_OFF_RELOAD: rd_mux = {16'h0000, reload_r};
            CAM_OFF_CMP:    rd_mux = {16'h0000, cmp_r};
            CAM_OFF_STAT:   rd_mux = {30'h0000_0000, stat_r};
            CAM_OFF_MASK:   rd_mux = {30'h0000_0000, mask_r};
            CAM_OFF_PIN:    rd_mux = {29'h0000_0000, sec_r, module_pin_o, pin_q_r};
            default:        rd_ok  = 1'b0;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= CAM_RESP_OK;
            rvalid_r  <= 1'b0;
            rresp_r   <= CAM_RESP_OK;
            rdata_r   <= 32'h0000_0000;
        end else if (clk_en) begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_r <= 1'b1;
                aw_addr_r <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_r <= 1'b1;
                w_data_r <= s_axi_wdata;
                w_strb_r <= s_axi_wstrb;
            end
            if (wr_fire) begin
                aw_hold_r <= 1'b0;
                w_hold_r  <= 1'b0;
                bvalid_r  <= 1'b1;
                bresp_r   <= wr_ok ? CAM_RESP_OK : CAM_RESP_ERR;
            end else if (bvalid_r && s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_r <= 1'b1;
                rdata_r  <= rd_mux;
                rresp_r  <= rd_ok ? CAM_RESP_OK : CAM_RESP_ERR;
            end else if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ****************************************
    // counter time base
    // ****************************************
    // counter advances one step per enabled clock; clock-source selection lives elsewhere
    wire logic tick     = run_r;
    wire logic ovf      = tick && (&cnt_r);
    wire logic lo_roll  = tick && cnt_r[7:0] == CAM_B8_MAX;
    always_comb begin
        cnt_nxt = cnt_r;
        if (wr_cnt) cnt_nxt = merge16(cnt_r, w_data_r, w_strb_r);
        else if (ovf) cnt_nxt = reload_r;
        else if (tick) cnt_nxt = cnt_r + 16'h0001;
    end

    // ****************************************
    // compare, capture and outputs
    // ****************************************
    // module_pin_i assumed synchronous; one registered sample gives the edge
    wire logic rise     = module_pin_i && !pin_q_r;
    wire logic fall     = !module_pin_i && pin_q_r;
    wire logic cap_ev   = mode == CAM_M_CAPTURE &&
                          ((rise && mode_r[CAM_B_CAPP]) || (fall && mode_r[CAM_B_CAPN]));
    wire logic match    = cnt_r == cmp_r;
    wire logic match_ev = (mode == CAM_M_SWTIMER || mode == CAM_M_HSOUT) && match;
    wire logic pwm_mode = mode == CAM_M_PWM8 || mode == CAM_M_PWM16 || mode == CAM_M_PWM2X8;
    wire logic pri_hi   = mode == CAM_M_PWM16 ? !(cnt_r < cmp_r)
                                              : !(cnt_r[7:0] < cmp_r[7:0]);
    wire logic sec_hi   = !(cnt_r[7:0] < cmp_r[15:8]);

    always_comb begin
        cmp_nxt = cmp_r;
        if (wr_cmp) cmp_nxt = merge16(cmp_r, w_data_r, w_strb_r);
        else if (cap_ev) cmp_nxt = cnt_r;
        else if (mode == CAM_M_PWM8 && lo_roll) cmp_nxt = {cmp_r[15:8], cmp_r[15:8]};
    end

    always_comb begin
        stat_nxt = stat_r;
        if (rd_stat) stat_nxt = '0;
        if (wr_stat) stat_nxt = stat_r & ~w_data_r[CAM_STAT_W-1:0];
        // hardware set wins over a clear in the same cycle
        if (cap_ev || match_ev) stat_nxt[CAM_S_FLAG] = 1'b1;
        if (ovf) stat_nxt[CAM_S_OVF] = 1'b1;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mode_r   <= CAM_MODE_RST;
            run_r    <= 1'b0;
            cnt_r    <= CAM_W16_RST;
            reload_r <= CAM_W16_RST;
            cmp_r    <= CAM_W16_RST;
            stat_r   <= '0;
            mask_r   <= '0;
            pin_q_r  <= 1'b0;
            hs_r     <= 1'b0;
            pwm_r    <= 1'b0;
            sec_r    <= 1'b0;
        end else if (clk_en) begin
            if (wr_mode && w_strb_r[0]) mode_r <= w_data_r[7:0];
            if (wr_ctrl && w_strb_r[0]) run_r <= w_data_r[CAM_B_RUN];
            if (wr_rld) reload_r <= merge16(reload_r, w_data_r, w_strb_r);
            if (wr_mask && w_strb_r[0]) mask_r <= w_data_r[CAM_STAT_W-1:0];
            cnt_r   <= cnt_nxt;
            cmp_r   <= cmp_nxt;
            stat_r  <= stat_nxt;
            pin_q_r <= module_pin_i;
            if (mode == CAM_M_HSOUT && match) hs_r <= !hs_r;
            pwm_r <= pri_hi ^ mode_r[CAM_B_INV];
            sec_r <= mode == CAM_M_PWM2X8 && (sec_hi ^ mode_r[CAM_B_INV]);
        end
    end

    // pin driven only in output modes; in idle and capture it is released
    assign module_pin_oe     = mode == CAM_M_HSOUT || pwm_mode;
    assign module_pin_o      = mode == CAM_M_HSOUT ? hs_r : (pwm_mode && pwm_r);
    assign secondary_pwm_out = sec_r;
    assign irq = (stat_r[CAM_S_FLAG] && mode_r[CAM_B_IRQEN] && mask_r[CAM_S_FLAG]) ||
                 (stat_r[CAM_S_OVF] && mask_r[CAM_S_OVF]);
endmodule

//--- design/cam_pkg.sv
// shared constants for the counter array compare/capture module
package cam_pkg;
    // register byte offsets
    localparam logic [7:0] CAM_OFF_CTRL   = 8'h00;
    localparam logic [7:0] CAM_OFF_MODE   = 8'h04;
    localparam logic [7:0] CAM_OFF_CNT    = 8'h08;
    localparam logic [7:0] CAM_OFF_RELOAD = 8'h0C;
    localparam logic [7:0] CAM_OFF_CMP    = 8'h10;
    localparam logic [7:0] CAM_OFF_STAT   = 8'h14;
    localparam logic [7:0] CAM_OFF_MASK   = 8'h18;
    localparam logic [7:0] CAM_OFF_PIN    = 8'h1C;
    // module_mode_reg field positions
    localparam int CAM_B_IRQEN  = 0;
    localparam int CAM_B_PWM    = 1;
    localparam int CAM_B_TOG    = 2;
    localparam int CAM_B_MAT    = 3;
    localparam int CAM_B_CAPN   = 4;
    localparam int CAM_B_CAPP   = 5;
    localparam int CAM_B_ECOM   = 6;
    localparam int CAM_B_INV    = 7;
    // ctrl field positions
    localparam int CAM_B_RUN    = 0;
    // status / mask field positions
    localparam int CAM_S_FLAG   = 0;
    localparam int CAM_S_OVF    = 1;
    localparam int CAM_STAT_W   = 2;
    // reset values, byte maximum and response codes
    localparam logic [7:0]  CAM_MODE_RST = 8'h00;
    localparam logic [15:0] CAM_W16_RST  = 16'h0000;
    localparam logic [7:0]  CAM_B8_MAX   = 8'hFF;
    localparam logic [1:0]  CAM_RESP_OK  = 2'b00;
    localparam logic [1:0]  CAM_RESP_ERR = 2'b10;
    typedef enum logic [2:0] {
        CAM_M_IDLE, CAM_M_CAPTURE, CAM_M_SWTIMER, CAM_M_HSOUT,
        CAM_M_PWM8, CAM_M_PWM16, CAM_M_PWM2X8
    } cam_mode_e;
endpackage

//--- design/cam_mode_dec.sv
// mode decoder for the module mode register
`timescale 1ns/1ps
module cam_mode_dec
    import cam_pkg::*;
(
    // mode register
    input  wire logic [7:0] mode_bits,
    // decoded mode
    output cam_mode_e       mode
);
    wire logic ecom = mode_bits[CAM_B_ECOM];
    wire logic capp = mode_bits[CAM_B_CAPP];
    wire logic capn = mode_bits[CAM_B_CAPN];
    wire logic mat  = mode_bits[CAM_B_MAT];
    wire logic tog  = mode_bits[CAM_B_TOG];
    wire logic pwm  = mode_bits[CAM_B_PWM];
    wire logic cap_only = !ecom && (capp || capn) && !mat && !tog && !pwm;
    wire logic cmp_sel  = ecom && !capp && !capn;
    // module_irq_en and pwm_invert take no part in the selection
    assign mode = cap_only                      ? CAM_M_CAPTURE :
                  (cmp_sel && mat && !tog && !pwm) ? CAM_M_SWTIMER :
                  (cmp_sel && mat && tog && !pwm)  ? CAM_M_HSOUT :
                  (cmp_sel && !mat && !tog && pwm) ? CAM_M_PWM8 :
                  (cmp_sel && mat && !tog && pwm)  ? CAM_M_PWM16 :
                  (cmp_sel && !mat && tog && pwm)  ? CAM_M_PWM2X8 :
                  CAM_M_IDLE;
endmodule

//--- verif/cam_properties.sv
// port checker for the compare/capture module
`timescale 1ns/1ps
module cam_properties
    import cam_pkg::*;
(
    // clock, reset
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        clk_en,
    // bus handshakes
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // pin and interrupt
    input wire logic        module_pin_oe,
    input wire logic        secondary_pwm_out,
    input wire logic        irq
);
    // ****
    // properties
    // ****
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && clk_en;
    endsequence
    sequence s_rd_take;
        s_axi_arvalid && s_axi_arready && clk_en;
    endsequence
    AST_WR_ANSWER: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid)
        else $error("write response missing");
    AST_RD_ANSWER: assert property (s_rd_take |=> s_axi_rvalid)
        else $error("read response missing");
    AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    AST_W_REFUSE: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken during response");
    AST_AR_REFUSE: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken during response");
    AST_SEC_OFF: assert property ((!module_pin_oe) [*2] |-> !secondary_pwm_out)
        else $error("secondary active outside pwm");
    AST_RST_QUIET: assert property ($rose(aresetn) |-> !module_pin_oe && !irq && !secondary_pwm_out)
        else $error("outputs active after reset");
endmodule
bind cam_top cam_properties i_props (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .module_pin_oe(module_pin_oe), .secondary_pwm_out(secondary_pwm_out), .irq(irq));

//--- verif/cam_pin_source.sv
// external source and load on the module pin
`timescale 1ns/1ps
module cam_pin_source (
    // design side
    input  wire logic module_pin_o,
    input  wire logic module_pin_oe,
    // level offered by the outside source
    input  wire logic drive_lvl,
    // level seen at the pin input
    output logic      module_pin_i
);
    // the source yields while the design drives, so no contention is modelled
    assign module_pin_i = module_pin_oe ? module_pin_o : drive_lvl;
endmodule

//--- verif/counter_array_module_modes_bench.sv
// self-checking bench for the compare/capture module
`timescale 1ns/1ps
module counter_array_module_modes_bench;
    import cam_pkg::*;
    logic        aclk = 0, aresetn = 0, clk_en = 1, awv = 0, wv = 0, bready = 0;
    logic        arv = 0, rready = 0, drive_lvl = 0, last, hit;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00, m8;
    logic [31:0] wdata = 32'h0, rd, rdata;
    logic [3:0]  wstrb = 4'hF;
    logic        awready, wready, bvalid, arready, rvalid, pin_i, pin_o, pin_oe, sec, irq;
    logic [1:0]  bresp, rresp, br, rr;
    logic [15:0] v, c;
    logic [7:0]  pm [3] = '{8'h42, 8'h4A, 8'h46};
    int          fails = 0, compares = 0, cyc = 0, seed = 28, i, n;
    // ****
    // design and partner
    // ****
    cam_top i_dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
        .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .module_pin_i(pin_i), .module_pin_o(pin_o), .module_pin_oe(pin_oe),
        .secondary_pwm_out(sec), .irq(irq));
    cam_pin_source i_src (.module_pin_o(pin_o), .module_pin_oe(pin_oe), .drive_lvl(drive_lvl),
        .module_pin_i(pin_i));
    always #5 aclk = ~aclk;
    // ****
    // tasks and expectations
    // ****
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = awv && awready;
            tw = wv && wready;
            @(posedge aclk);
            if (ta) awv <= 1'b0;
            if (tw) wv <= 1'b0;
        end while (awv || wv);
        do @(negedge aclk); while (!bvalid);
        br = bresp;
        @(posedge aclk);
        bready <= 1'b0;
    endtask
    task rdr(input logic [7:0] a);
        logic ta;
        @(posedge aclk);
        araddr <= a;
        arv <= 1'b1;
        rready <= 1'b1;
        do begin
            @(negedge aclk);
            ta = arv && arready;
            @(posedge aclk);
            if (ta) arv <= 1'b0;
        end while (!ta);
        do @(negedge aclk); while (!rvalid);
        rd = rdata;
        rr = rresp;
        @(posedge aclk);
        rready <= 1'b0;
    endtask
    // returns {oe, secondary, primary}; inversion modelled on the pin only, the bench never inverts the double channel
    function logic [2:0] pexp(input int m, input logic [15:0] cn, input logic [15:0] cp, input logic inv);
        logic p;
        p = (m == 1) ? (cn >= cp) : (cn[7:0] >= cp[7:0]);
        return {1'b1, (m == 2) && (cn[7:0] >= cp[15:8]), p ^ inv};
    endfunction
    task summarize;
        $display("checks %0d mismatches %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    always @(posedge aclk) begin
        cyc++;
        if (cyc == 6000) begin
            fails++;
            summarize();
        end
    end
    // ****
    // scenarios
    // ****
    initial begin
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        rdr(CAM_OFF_MODE);
        chk("mode_rst", rd, 32'h0);
        rdr(8'h20);
        chk("rresp_unmapped", rr, CAM_RESP_ERR);
        wr(8'h20, 32'h1);
        chk("bresp_unmapped", br, CAM_RESP_ERR);
        wr(CAM_OFF_MASK, 32'h1);
        wr(CAM_OFF_CNT, 32'h1000);
        rdr(CAM_OFF_CNT);
        chk("cnt_stopped", rd, 32'h1000);
        $display("test reset done");
        for (i = 0; i < 6; i++) begin
            v = 16'($random(seed));
            m8 = (i < 2) ? 8'h21 : (i < 4) ? 8'h11 : 8'h31;
            hit = m8[5] && !i[0] || m8[4] && i[0];
            wr(CAM_OFF_MODE, 32'h0);
            drive_lvl <= i[0];
            rdr(CAM_OFF_STAT);
            wr(CAM_OFF_CMP, 32'h0);
            wr(CAM_OFF_CNT, {16'h0, v});
            wr(CAM_OFF_MODE, {24'h0, m8});
            drive_lvl <= !i[0];
            repeat (4) @(posedge aclk);
            @(negedge aclk);
            chk("irq_capture", irq, hit);
            rdr(CAM_OFF_CMP);
            chk("capture", rd, hit ? {16'h0, v} : 32'h0);
            rdr(CAM_OFF_STAT);
            chk("flag_capture", rd[0], hit);
        end
        wr(CAM_OFF_MODE, 32'h0);
        wr(CAM_OFF_CMP, {16'h0, v});
        rdr(CAM_OFF_STAT);
        chk("idle_flag", rd[0], 1'b0);
        $display("test capture done");
        wr(CAM_OFF_MODE, 32'h49);
        repeat (3) @(posedge aclk);
        @(negedge aclk);
        chk("irq_timer", irq, 1'b1);
        rdr(CAM_OFF_STAT);
        chk("flag_timer", rd[0], 1'b1);
        wr(CAM_OFF_CNT, {16'h0, v ^ 16'h0001});
        rdr(CAM_OFF_STAT);
        rdr(CAM_OFF_STAT);
        chk("flag_cleared", rd[0], 1'b0);
        $display("test timer done");
        for (i = 0; i < 6; i++) begin
            v = 16'($random(seed));
            c = 16'($random(seed));
            wr(CAM_OFF_CNT, {16'h0, v});
            wr(CAM_OFF_CMP, {16'h0, c});
            wr(CAM_OFF_MODE, {24'h0, pm[i % 3] | ((i >= 3 && i % 3 != 2) ? 8'h80 : 8'h00)});
            repeat (2) @(posedge aclk);
            @(negedge aclk);
            chk("pwm_out", {pin_oe, sec, pin_o}, pexp(i % 3, v, c, i >= 3 && i % 3 != 2));
        end
        $display("test pwm done");
        wr(CAM_OFF_CMP, 32'h5A00);
        wr(CAM_OFF_MODE, 32'h42);
        wr(CAM_OFF_RELOAD, 32'h12F0);
        wr(CAM_OFF_CNT, 32'hFFF0);
        wr(CAM_OFF_CTRL, 32'h1);
        repeat (60) @(posedge aclk);
        wr(CAM_OFF_CTRL, 32'h0);
        rdr(CAM_OFF_CNT);
        chk("cnt_reload", rd[15:8], 8'h13);
        rdr(CAM_OFF_CMP);
        chk("cmp_buffer", rd, 32'h5A5A);
        rdr(CAM_OFF_STAT);
        chk("overflow", rd[1], 1'b1);
        $display("test reload done");
        wr(CAM_OFF_RELOAD, 32'hFFF0);
        wr(CAM_OFF_CNT, 32'hFFF0);
        wr(CAM_OFF_CMP, 32'hFFF8);
        wr(CAM_OFF_MODE, 32'h4C);
        wr(CAM_OFF_CTRL, 32'h1);
        repeat (4) @(posedge aclk);
        @(negedge aclk);
        last = pin_o;
        n = 0;
        repeat (64) begin
            @(negedge aclk);
            if (pin_o !== last) n++;
            last = pin_o;
        end
        chk("toggles", n, 32'd4);
        chk("hs_oe", pin_oe, 1'b1);
        // enable low: a running 16-step period would toggle once in 16 cycles unless frozen
        @(posedge aclk);
        clk_en <= 1'b0;
        @(negedge aclk);
        last = pin_o;
        n = 0;
        repeat (16) begin
            @(negedge aclk);
            if (pin_o !== last) n++;
        end
        chk("freeze", n, 32'd0);
        @(posedge aclk);
        clk_en <= 1'b1;
        wr(CAM_OFF_CTRL, 32'h0);
        $display("test toggle done");
        summarize();
    end
endmodule
